// [rtl/pio_pkg.sv]
package pio_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int PIO_PORTS = 11;
  localparam int PIO_LINES = 88;
  localparam int PIO_GROUPS = 22;
  localparam int PIO_AW = 6;
  localparam int NMI_LINE = 69;
  localparam int OD_LINE_A = 57;
  localparam int OD_LINE_B = 73;
  localparam int NMI_PORT = 8;
  localparam int NMI_BIT = 5;
  localparam int DIR_UNLOCK_BIT = 2;
  localparam int READBACK_BIT = 0;
  localparam int PU_BIT_ONE = 1;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [5:0] ADDR_DATA_BASE = 6'h00;
  localparam logic [5:0] ADDR_DIR_BASE = 6'h10;
  localparam logic [5:0] ADDR_PULLUP0 = 6'h20;
  localparam logic [5:0] ADDR_PULLUP1 = 6'h21;
  localparam logic [5:0] ADDR_PULLUP2 = 6'h22;
  localparam logic [5:0] ADDR_READBACK = 6'h24;
  localparam logic [5:0] ADDR_PROTECT = 6'h28;
  localparam logic [5:0] ADDR_PMODE = 6'h2c;

  // ************************************************************
  // Reset values and masks
  // ************************************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PULLUP1_EXP = 8'h02;
  localparam logic [87:0] BUS_LINE_MASK = 88'h00_0000_0000_ffff_ffff_ffff;
  // Groups of P0 to P3, low nibble of P4, and P5
  localparam logic [21:0] BUS_PULL_MASK = 22'h0dff;
  localparam logic [7:0] PULLUP2_MASK = 8'h3f;

  typedef enum logic [1:0] {
    PIO_SINGLE = 2'b00,
    PIO_MEMEXP = 2'b01,
    PIO_RSVD = 2'b10,
    PIO_MICRO = 2'b11
  } pio_mode_t;

endpackage

// [rtl/pio_pad_if.sv]
`timescale 1ns/10ps
interface pio_pad_if;
  import pio_pkg::*;
  logic [PIO_LINES-1:0] dir;
  logic [PIO_LINES-1:0] latch;
  logic [PIO_GROUPS-1:0] pullSel;
  logic busMode;
  logic [PIO_LINES-1:0] periphOutEn;
  logic [PIO_LINES-1:0] periphOut;

  modport regs (
    output dir, latch, pullSel, busMode, periphOutEn, periphOut
  );
  modport pads (
    input dir, latch, pullSel, busMode, periphOutEn, periphOut
  );
endinterface

// [rtl/pio_sync.sv]
`timescale 1ns/10ps
module pio_sync
  import pio_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Async levels
  input wire logic [PIO_LINES:0] asyncIn,
  // Synchronised levels
  output logic [PIO_LINES:0] syncOut
);

  typedef struct packed {
    logic [PIO_LINES:0] stage1;
    logic [PIO_LINES:0] stage2;
  } pio_sync_t;

  pio_sync_t s_q;
  pio_sync_t s_d;

  // No reset: the boot strap must already be settled when rst is released
  always_comb begin
    s_d = s_q;
    s_d.stage1 = asyncIn;
    s_d.stage2 = s_q.stage1;
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  assign syncOut = s_q.stage2;

endmodule

// [rtl/pio_pad.sv]
`timescale 1ns/10ps
module pio_pad
  import pio_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register side
  pio_pad_if.pads padIf,
  // Pin drivers
  output logic [PIO_LINES-1:0] pinOut,
  output logic [PIO_LINES-1:0] pinOe,
  output logic [PIO_LINES-1:0] pullUpEn
);

  typedef struct packed {
    logic [PIO_LINES-1:0] out;
    logic [PIO_LINES-1:0] oe;
    logic [PIO_LINES-1:0] pull;
  } pio_pad_t;

  pio_pad_t s_q;
  pio_pad_t s_d;
  logic [PIO_LINES-1:0] nxtOut;
  logic [PIO_LINES-1:0] nxtOe;
  logic [PIO_LINES-1:0] nxtPull;

  genvar i;
  generate
    for (i = 0; i < PIO_LINES; i++) begin : g_line
      logic drive;
      logic val;
      logic busLock;
      assign drive = padIf.dir[i] | padIf.periphOutEn[i]; // R05 R18
      assign val = padIf.periphOutEn[i] ? padIf.periphOut[i] : padIf.latch[i]; // R08
      assign busLock = padIf.busMode & BUS_PULL_MASK[i/4]; // R10
      if (i == NMI_LINE) begin : g_nmi
        assign nxtOe[i] = 1'b0; // R02
        assign nxtOut[i] = 1'b0;
        assign nxtPull[i] = 1'b0; // R17
      end else if (i == OD_LINE_A || i == OD_LINE_B) begin : g_od
        // Only ever sinks; a one releases the pin
        assign nxtOe[i] = drive & ~val; // R13
        assign nxtOut[i] = 1'b0; // R13
        assign nxtPull[i] = 1'b0; // R17
      end else begin : g_std
        assign nxtOe[i] = drive; // R18
        assign nxtOut[i] = val; // R08
        assign nxtPull[i] = padIf.pullSel[i/4] & ~drive & ~busLock; // R09
      end
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    s_d.out = nxtOut;
    s_d.oe = nxtOe;
    s_d.pull = nxtPull;
    if (rst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  assign pinOut = s_q.out;
  assign pinOe = s_q.oe;
  assign pullUpEn = s_q.pull;

endmodule

// [rtl/pio_ports.sv]
`timescale 1ns/10ps
// What this block does
// R01 - 88 lines in eleven ports, per-line direction, pull-ups chosen per four lines.
// R02 - NMI-shared line is input only, unpulled, read at port 8 bit 5.
// R03 - NMI-shared line has no direction bit.
// R04 - Software clears direction bit for peripheral inputs and converter outputs.
// R05 - Peripheral outputs other than the converter drive whatever the direction bit.
// R06 - In bus modes, direction and data writes to bus-control lines are ignored.
// R07 - Input line reads pin level; writes still update the latch.
// R08 - Output line reads latch; latch drives the pin.
// R09 - Pull-up only when group bit is one and direction bit zero.
// R10 - In bus modes bus-port pull-ups have no effect; bits stay writable.
// R11 - Readback select set makes port 1 read return the latch.
// R12 - Software writes ports 7 and 9 direction right after unlocking.
// R13 - Open-drain lines of ports 7 and 9 float on a one.
// R14 - Hardware reset: pull-up register 1 is zero or 02 by boot pin.
// R15 - Soft resets: pull-up register 1 is zero or 02 by mode field.
// R16 - Mode change from single-chip to 01 or 11 sets pull-up bit one.
// R17 - Open-drain lines and NMI-shared line never get pull-ups.
// R18 - Direction bit one makes the line an output driving the latch.
module pio_ports
  import pio_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic softRst,
  // Register port
  input wire logic [PIO_AW-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // Peripheral outputs
  input wire logic [PIO_LINES-1:0] periphOutEn,
  input wire logic [PIO_LINES-1:0] periphOut,
  // Pins
  input wire logic bootModePin,
  input wire logic [PIO_LINES-1:0] pinIn,
  output logic [PIO_LINES-1:0] pinOut,
  output logic [PIO_LINES-1:0] pinOe,
  output logic [PIO_LINES-1:0] pullUpEn,
  // Status
  output logic [1:0] processorMode
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [PIO_PORTS-1:0][7:0] lineDir;
    logic [PIO_PORTS-1:0][7:0] lineData;
    logic [7:0] pullup0;
    logic [7:0] pullup1;
    logic [7:0] pullup2;
    logic [7:0] readbackCtl;
    logic [7:0] writeProtect;
    pio_mode_t procMode;
    logic [7:0] rdData;
  } pio_state_t;

  pio_state_t s_q;
  pio_state_t s_d;

  logic [PIO_LINES:0] syncLevels;
  logic [PIO_LINES-1:0] pinSync;
  logic bootSync;
  logic busMode;
  logic [PIO_LINES-1:0] lockMask;
  logic [PIO_LINES-1:0] dirFlat;
  logic [PIO_LINES-1:0] latFlat;
  logic [PIO_LINES-1:0] readView;
  logic [PIO_PORTS-1:0][7:0] readPorts;

  pio_pad_if padIf ();

  // ************************************************************
  // Pin and strap synchronisers
  // ************************************************************
  pio_sync u_sync (
    .core_clk (core_clk),
    .asyncIn  ({bootModePin, pinIn}),
    .syncOut  (syncLevels)
  );

  assign pinSync = syncLevels[PIO_LINES-1:0];
  assign bootSync = syncLevels[PIO_LINES];

  // ************************************************************
  // Mode and flattened views
  // ************************************************************
  assign busMode = (s_q.procMode == PIO_MEMEXP) || (s_q.procMode == PIO_MICRO);
  assign lockMask = busMode ? BUS_LINE_MASK : '0; // R06
  assign dirFlat = s_q.lineDir;
  assign latFlat = s_q.lineData;

  // Input lines read the pin, output lines and all of port 1 with readback set the latch
  genvar gl;
  generate
    for (gl = 0; gl < PIO_LINES; gl++) begin : g_read
      if (gl == NMI_LINE) begin : g_nmi
        assign readView[gl] = pinSync[gl]; // R02
      end else if (gl / 8 == 1) begin : g_p1
        assign readView[gl] = (dirFlat[gl] | s_q.readbackCtl[READBACK_BIT])
          ? latFlat[gl] : pinSync[gl]; // R11
      end else begin : g_std
        assign readView[gl] = dirFlat[gl] ? latFlat[gl] : pinSync[gl]; // R07 R08
      end
    end
  endgenerate

  assign readPorts = readView;

  // ************************************************************
  // Pad control
  // ************************************************************
  assign padIf.dir = dirFlat;
  assign padIf.latch = latFlat;
  assign padIf.pullSel = {s_q.pullup2[5:0], s_q.pullup1, s_q.pullup0}; // R01
  assign padIf.busMode = busMode;
  assign padIf.periphOutEn = periphOutEn;
  assign padIf.periphOut = periphOut;

  pio_pad u_pad (
    .core_clk (core_clk),
    .rst      (rst),
    .padIf    (padIf),
    .pinOut   (pinOut),
    .pinOe    (pinOe),
    .pullUpEn (pullUpEn)
  );

  // ************************************************************
  // Register file
  // ************************************************************
  always_comb begin
    logic [7:0] lock;
    logic [7:0] nextVal;
    logic wroteProtect;
    pio_mode_t newMode;
    lock = '0;
    nextVal = '0;
    wroteProtect = 1'b0;
    newMode = PIO_SINGLE;
    s_d = s_q;
    s_d.rdData = '0;

    // Writes
    if (regWrEn) begin
      for (int p = 0; p < PIO_PORTS; p++) begin
        lock = lockMask[p*8 +: 8];
        if (regAddr == ADDR_DATA_BASE + 6'(p)) begin
          // Latch updates even for input lines
          s_d.lineData[p] = (regWrData & ~lock) | (s_q.lineData[p] & lock); // R06 R07
        end
        if (regAddr == ADDR_DIR_BASE + 6'(p)) begin
          nextVal = (regWrData & ~lock) | (s_q.lineDir[p] & lock); // R06 R01
          if (p == NMI_PORT) begin
            nextVal[NMI_BIT] = 1'b0; // R03
          end
          // Ports 7 and 9 need the one-shot unlock
          if ((p != 7 && p != 9) || s_q.writeProtect[DIR_UNLOCK_BIT]) begin // R12
            s_d.lineDir[p] = nextVal;
          end
        end
      end
      case (regAddr)
        ADDR_PULLUP0: begin
          s_d.pullup0 = regWrData; // R10
        end
        ADDR_PULLUP1: begin
          s_d.pullup1 = regWrData; // R10
        end
        ADDR_PULLUP2: begin
          s_d.pullup2 = regWrData & PULLUP2_MASK;
        end
        ADDR_READBACK: begin
          s_d.readbackCtl = regWrData;
        end
        ADDR_PROTECT: begin
          s_d.writeProtect = regWrData;
          wroteProtect = 1'b1;
        end
        ADDR_PMODE: begin
          newMode = pio_mode_t'(regWrData[1:0]);
          s_d.procMode = newMode;
          if (s_q.procMode == PIO_SINGLE &&
              (newMode == PIO_MEMEXP || newMode == PIO_MICRO)) begin
            s_d.pullup1[PU_BIT_ONE] = 1'b1; // R16
          end
        end
        default: begin
        end
      endcase
      // Unlock lasts exactly one following write
      if (!wroteProtect) begin
        s_d.writeProtect[DIR_UNLOCK_BIT] = 1'b0; // R12
      end
    end

    // Reads, answered one cycle later
    if (regRdEn) begin
      for (int p = 0; p < PIO_PORTS; p++) begin
        if (regAddr == ADDR_DATA_BASE + 6'(p)) begin
          s_d.rdData = readPorts[p];
        end
        if (regAddr == ADDR_DIR_BASE + 6'(p)) begin
          s_d.rdData = s_q.lineDir[p];
        end
      end
      case (regAddr)
        ADDR_PULLUP0: begin
          s_d.rdData = s_q.pullup0;
        end
        ADDR_PULLUP1: begin
          s_d.rdData = s_q.pullup1;
        end
        ADDR_PULLUP2: begin
          s_d.rdData = s_q.pullup2;
        end
        ADDR_READBACK: begin
          s_d.rdData = s_q.readbackCtl;
        end
        ADDR_PROTECT: begin
          s_d.rdData = s_q.writeProtect;
        end
        ADDR_PMODE: begin
          s_d.rdData = {6'h00, s_q.procMode};
        end
        default: begin
        end
      endcase
    end

    // Software, watchdog or oscillation-stop reset keeps the mode
    if (softRst) begin
      s_d.lineDir = '0;
      s_d.lineData = '0;
      s_d.pullup0 = RST_ZERO;
      s_d.pullup2 = RST_ZERO;
      s_d.readbackCtl = RST_ZERO;
      s_d.writeProtect = RST_ZERO;
      s_d.rdData = '0;
      // A same-cycle mode write loses against the reset
      s_d.procMode = s_q.procMode;
      s_d.pullup1 = busMode ? RST_PULLUP1_EXP : RST_ZERO; // R15
    end

    // Hardware reset takes the mode from the boot strap
    if (rst) begin
      s_d = '0;
      s_d.procMode = bootSync ? PIO_MICRO : PIO_SINGLE;
      s_d.pullup1 = bootSync ? RST_PULLUP1_EXP : RST_ZERO; // R14
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  assign regRdData = s_q.rdData;
  assign processorMode = s_q.procMode;

endmodule

// [sim/pio_ports_assertions.sv]
`timescale 1ns/10ps
module pio_ports_assertions
  import pio_pkg::*;
(
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic softRst,
  // Register port
  input wire logic [PIO_AW-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  // Peripherals and pins
  input wire logic [PIO_LINES-1:0] periphOutEn,
  input wire logic [PIO_LINES-1:0] periphOut,
  input wire logic bootModePin,
  input wire logic [PIO_LINES-1:0] pinIn,
  input wire logic [PIO_LINES-1:0] pinOut,
  input wire logic [PIO_LINES-1:0] pinOe,
  input wire logic [PIO_LINES-1:0] pullUpEn,
  input wire logic [1:0] processorMode
);
  // ************************************************************
  // Pin and mode checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_nmi_free; !pinOe[NMI_LINE] && !pullUpEn[NMI_LINE]; endproperty
  property p_od_pull; !pullUpEn[OD_LINE_A] && !pullUpEn[OD_LINE_B]; endproperty
  property p_od_low;
    !(pinOe[OD_LINE_A] && pinOut[OD_LINE_A]) && !(pinOe[OD_LINE_B] && pinOut[OD_LINE_B]);
  endproperty
  property p_pull_in; ~|(pullUpEn & pinOe); endproperty
  // First cycle out of reset skipped: pads still hold reset state
  property p_periph;
    periphOutEn[52] && !$past(rst) |=> pinOe[52] && pinOut[52] == $past(periphOut[52]);
  endproperty
  property p_boot; $fell(rst) |-> processorMode == (bootModePin ? PIO_MICRO : PIO_SINGLE);
  endproperty
  property p_bus_pull;
    processorMode[0] && $past(processorMode[0]) |-> ~|pullUpEn[35:0] && ~|pullUpEn[47:40];
  endproperty
  property p_soft_mode; softRst |=> processorMode == $past(processorMode); endproperty

  a_nmi_free: assert property (p_nmi_free) else $error("nmi line driven or pulled");
  a_od_pull: assert property (p_od_pull) else $error("open drain line pulled");
  a_od_low: assert property (p_od_low) else $error("open drain line driven high");
  a_pull_in: assert property (p_pull_in) else $error("pull-up on driven line");
  a_periph: assert property (p_periph) else $error("peripheral output not driven");
  a_boot: assert property (p_boot) else $error("mode after reset wrong");
  a_bus_pull: assert property (p_bus_pull) else $error("bus port pulled in bus mode");
  a_soft_mode: assert property (p_soft_mode) else $error("mode lost on soft reset");

  c_periph: cover property (periphOutEn[52] ##1 pinOe[52]);
  c_bus: cover property (processorMode == PIO_MEMEXP);
  c_soft: cover property (softRst);
endmodule

bind pio_ports pio_ports_assertions chk (
  .core_clk(core_clk),
  .rst(rst),
  .softRst(softRst),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWrEn(regWrEn),
  .regRdEn(regRdEn),
  .regRdData(regRdData),
  .periphOutEn(periphOutEn),
  .periphOut(periphOut),
  .bootModePin(bootModePin),
  .pinIn(pinIn),
  .pinOut(pinOut),
  .pinOe(pinOe),
  .pullUpEn(pullUpEn),
  .processorMode(processorMode)
);

// [sim/pio_pin_model.sv]
`timescale 1ns/10ps
module pio_pin_model
  import pio_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Device drivers
  input wire logic [PIO_LINES-1:0] pinOut,
  input wire logic [PIO_LINES-1:0] pinOe,
  input wire logic [PIO_LINES-1:0] pullUpEn,
  // Board drivers
  input wire logic [PIO_LINES-1:0] extDrv,
  input wire logic [PIO_LINES-1:0] extVal,
  // Wire levels
  output logic [PIO_LINES-1:0] pinIn
);
  // Undriven lines wander, so a stale level never passes as valid
  logic [PIO_LINES-1:0] floatQ = '0;
  // Toggles on its own so an unknown pad state before reset never sticks
  always_ff @(posedge core_clk) begin
    floatQ <= ~floatQ;
  end
  assign pinIn = (pinOe & pinOut) | (~pinOe & extDrv & extVal)
               | (~pinOe & ~extDrv & (pullUpEn | floatQ));
endmodule

// [sim/programmable_io_ports_test.sv]
`timescale 1ns/10ps
module programmable_io_ports_test;
  import pio_pkg::*;
  logic core_clk = 1'b0;
  logic rst, softRst, regWrEn, regRdEn, bootModePin;
  logic [5:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [87:0] periphOutEn, periphOut, pinIn, pinOut, pinOe, pullUpEn, extDrv, extVal;
  logic [1:0] processorMode;
  int nMismatch = 0;
  int checkCount = 0;

  always #2.5 core_clk = ~core_clk;

  pio_ports dut (.core_clk(core_clk), .rst(rst), .softRst(softRst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .periphOutEn(periphOutEn), .periphOut(periphOut), .bootModePin(bootModePin),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
    .processorMode(processorMode));
  pio_pin_model board (.core_clk(core_clk), .pinOut(pinOut), .pinOe(pinOe),
    .pullUpEn(pullUpEn), .extDrv(extDrv), .extVal(extVal), .pinIn(pinIn));

  // ************************************************************
  // Bus and compare helpers
  // ************************************************************
  task automatic endSim;
    $display("Mismatches %0d of %0d checks", nMismatch, checkCount);
    if (nMismatch == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(logic [5:0] a, logic [7:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    chk("regRdData", exp, regRdData);
  endtask
  // Register, pad stage and pin synchroniser all lag
  task automatic settle;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic testPort6;
    extDrv[55:48] <= 8'hff;
    extVal[55:48] <= 8'h30;
    wr(ADDR_DIR_BASE + 6'h06, 8'h0f);
    wr(ADDR_DATA_BASE + 6'h06, 8'ha5);
    settle;
    chk("pinOe", 8'h0f, pinOe[55:48]);
    chk("pinOut", 8'h05, {4'h0, pinOut[51:48]});
    rd(ADDR_DATA_BASE + 6'h06, 8'h35);
    extDrv[55:48] <= 8'h00;
    wr(ADDR_PULLUP1, 8'h30);
    settle;
    chk("pullUpEn", 8'hf0, pullUpEn[55:48]);
    rd(ADDR_DATA_BASE + 6'h06, 8'hf5);
    @(posedge core_clk);
    periphOutEn[52] <= 1'b1;
    periphOut[52] <= 1'b1;
    settle;
    chk("pinOe", 8'h1f, pinOe[55:48]);
    chk("pullUpEn", 8'he0, pullUpEn[55:48]);
    @(posedge core_clk);
    periphOutEn[52] <= 1'b0;
  endtask
  task automatic testReadback;
    extDrv[15:8] <= 8'hff;
    extVal[15:8] <= 8'hc3;
    wr(ADDR_DATA_BASE + 6'h01, 8'h3c);
    settle;
    rd(ADDR_DATA_BASE + 6'h01, 8'hc3);
    wr(ADDR_READBACK, 8'h01);
    rd(ADDR_DATA_BASE + 6'h01, 8'h3c);
  endtask
  task automatic testOpenDrain;
    wr(ADDR_DIR_BASE + 6'h07, 8'h02);
    settle;
    chk("pinOe", 8'h00, pinOe[63:56]);
    wr(ADDR_PROTECT, 8'h04);
    wr(ADDR_DIR_BASE + 6'h07, 8'h02);
    settle;
    chk("pinOe", 8'h02, pinOe[63:56]);
    wr(ADDR_DATA_BASE + 6'h07, 8'h02);
    settle;
    chk("pinOe", 8'h00, pinOe[63:56]);
    wr(ADDR_PROTECT, 8'h04);
    wr(ADDR_DIR_BASE + 6'h07, 8'h00);
    wr(ADDR_PULLUP1, 8'h70);
    settle;
    chk("pullUpEn", 8'h0d, pullUpEn[63:56]);
  endtask
  task automatic testNmi;
    wr(ADDR_DIR_BASE + 6'h08, 8'hff);
    rd(ADDR_DIR_BASE + 6'h08, 8'hdf);
    extDrv[69] <= 1'b1;
    extVal[69] <= 1'b1;
    settle;
    chk("pinOe", 8'hdf, pinOe[71:64]);
    rd(ADDR_DATA_BASE + 6'h08, 8'h20);
  endtask
  task automatic testBusMode;
    wr(ADDR_PULLUP0, 8'h03);
    settle;
    chk("pullUpEn", 8'hff, pullUpEn[7:0]);
    wr(ADDR_PULLUP1, 8'h71);
    wr(ADDR_PMODE, 8'h01);
    rd(ADDR_PULLUP1, 8'h73);
    settle;
    chk("pullUpEn", 8'h00, pullUpEn[7:0]);
    chk("pullUpEn", 8'hf0, pullUpEn[39:32]);
    rd(ADDR_PULLUP0, 8'h03);
    wr(ADDR_DIR_BASE, 8'hff);
    rd(ADDR_DIR_BASE, 8'h00);
    settle;
    chk("pinOe", 8'h00, pinOe[7:0]);
    @(posedge core_clk);
    softRst <= 1'b1;
    @(posedge core_clk);
    softRst <= 1'b0;
    rd(ADDR_PULLUP1, RST_PULLUP1_EXP);
    rd(ADDR_PMODE, 8'h01);
  endtask
  task automatic testBootHigh;
    @(posedge core_clk);
    bootModePin <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("processorMode", 8'h03, {6'h00, processorMode});
    rd(ADDR_PULLUP1, RST_PULLUP1_EXP);
  endtask

  initial begin
    rst = 1'b1;
    {softRst, regWrEn, regRdEn, bootModePin} = 4'h0;
    regAddr = 6'h00;
    regWrData = 8'h00;
    {periphOutEn, periphOut, extDrv, extVal} = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("processorMode", 8'h00, {6'h00, processorMode});
    rd(ADDR_PULLUP1, RST_ZERO);
    testPort6;
    testReadback;
    testOpenDrain;
    testNmi;
    testBusMode;
    testBootHigh;
    endSim;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    nMismatch++;
    endSim;
  end
endmodule
